// *** logic/acis_defs.svh ***
// register offsets, field positions, masks and constants of the converter clock and input-select block
`ifndef ACIS_DEFS_SVH
`define ACIS_DEFS_SVH

`define ACIS_OFF_TIMING 4'h0
`define ACIS_OFF_AUX 4'h2
`define ACIS_OFF_MAIN 4'h4
`define ACIS_OFF_SCAN 4'h6

`define ACIS_MASK_TIMING 16'h9FFF
`define ACIS_MASK_AUX 16'h0707
`define ACIS_MASK_MAIN 16'h9F9F
`define ACIS_MASK_SCAN 16'h1FFF
`define ACIS_RESET_VALUE 16'h0000

`define ACIS_TIM_SRC_BIT 15
`define ACIS_TIM_AUTO_SAMPLE_TIME_HI 12
`define ACIS_TIM_AUTO_SAMPLE_TIME_LO 8
`define ACIS_TIM_DIV_HI 7
`define ACIS_TIM_DIV_LO 0

`define ACIS_AUX_NEG_B_HI 10
`define ACIS_AUX_NEG_B_LO 9
`define ACIS_AUX_POS_B_BIT 8
`define ACIS_AUX_NEG_A_HI 2
`define ACIS_AUX_NEG_A_LO 1
`define ACIS_AUX_POS_A_BIT 0

`define ACIS_MAIN_NEG_B_BIT 15
`define ACIS_MAIN_POS_B_HI 12
`define ACIS_MAIN_POS_B_LO 8
`define ACIS_MAIN_NEG_A_BIT 7
`define ACIS_MAIN_POS_A_HI 4
`define ACIS_MAIN_POS_A_LO 0

`define ACIS_TRIG_AUTO 3'h7
`define ACIS_DIV_RESERVED 8'h40
`define ACIS_POS_MAX 5'h0C
`define ACIS_ABSENT_LO 5'h06
`define ACIS_ABSENT_HI 5'h08
`define ACIS_AUX_NEG_HIGH 2'h3
`define ACIS_AUX_NEG_MID 2'h2
`define ACIS_AUX_POS_LOW_BASE 4'h0
`define ACIS_AUX_POS_HIGH_BASE 4'h3
`define ACIS_AUX_NEG_HIGH_BASE 4'h9
`define ACIS_AUX_NEG_MID_BASE 4'h6

`endif

// *** logic/acis_pkg.sv ***
// types shared by the converter clock and input-select block
`default_nettype none
package acis_pkg;
  typedef enum logic [1:0] {
    ACIS_IDLE = 2'b00,
    ACIS_SAMPLING = 2'b01,
    ACIS_CONVERTING = 2'b10
  } acis_state_t;
  typedef logic [3:0] acis_input_t;
endpackage : acis_pkg
`default_nettype wire

// *** logic/acis_top.sv ***
// converter clock, auto-sample timing and input multiplexer selection
//
// Overview of operation
// [R1] timing bit 15 picks internal RC clock when 1, system clock when 0
// [R2] five-bit auto-sample field gives sampling length in conversion-clock periods, 0 to 31
// [R3] auto-sample field only used when trigger source is 111
// [R4] divider field gives conversion period of (field+1) cycles; 0x40 and up reserved
// [R5] divider field ignored while the RC clock is chosen
// [R6] set-B aux negative: 11 inputs 9-11, 10 inputs 6-8 (reserved small), else low reference
// [R7] set-A aux negative decoded the same; every code reserved in 12-bit mode
// [R8] aux positive bit picks inputs 3-5 or 0-2; reserved in 12-bit mode
// [R9] channel-0 negative bit picks input 1 when set, low reference when clear
// [R10] channel-0 positive five-bit code selects input of that index, 0 to 12
// [R11] small package treats positive codes 6 to 8 as reserved
// [R12] thirteen-bit scan mask includes an input when its bit is 1
// [R13] mask bit x belongs to analog input x
// [R14] all mask bits writable; scanning an absent input converts the low reference
// [R15] unimplemented register bits ignore writes and read as zero
// [R16] implemented bits are read/write and clear to zero on reset
// [R17] scan drives channel-0 positive only in set A with scan enabled
// [R18] alternate flag swaps set A and set B each sample; clear means always A
// [R19] 12-bit mode flag chooses one-channel 12-bit or four-channel 10-bit operation
// [R20] trigger 111 ends sampling by internal count of programmed auto-sample time
// [R21] scan steps ascending through selected inputs, wrapping after the highest
`timescale 1ns/1ps
`default_nettype none
`include "acis_defs.svh"

module acis_top #(
  parameter int ADDR_WIDTH = 4,
  parameter bit SMALL_PACKAGE = 1'b0,
  parameter int NUM_INPUTS = 13
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_WIDTH-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic twelve_bit_mode,
  input wire logic [2:0] trigger_source,
  input wire logic scan_enable_set_a,
  input wire logic alternate_sample_flag,
  input wire logic rc_clock_tick,
  input wire logic sample_start,
  input wire logic conversion_done,
  output logic conv_clock_tick,
  output logic auto_sample_end,
  output logic sampling,
  output logic using_set_b,
  output logic [3:0] main_pos_input,
  output logic main_pos_low_ref,
  output logic main_neg_is_input1,
  output logic [3:0] aux_pos_base,
  output logic [3:0] aux_neg_base,
  output logic aux_neg_low_ref,
  output logic select_reserved,
  output logic divider_reserved,
  output logic [12:0] scan_mask_bits,
  output logic [3:0] scan_pointer
);

  // decode slices the low nibble, so narrower buses cannot be served
  if (ADDR_WIDTH < 4 || ADDR_WIDTH > 16) begin : g_bad_addr_width
    $error("acis_top: ADDR_WIDTH must be 4 to 16");
  end
  if (NUM_INPUTS != 13) begin : g_bad_num_inputs
    $error("acis_top: the multiplexer is built for 13 analog inputs");
  end

  // register storage
  logic [15:0] adc_timing_control;
  logic [15:0] adc_aux_channel_select;
  logic [15:0] adc_main_channel_select;
  logic [15:0] adc_scan_mask;

  // address decode
  wire logic [3:0] addr_low = reg_addr[3:0];
  wire logic addr_upper_zero = (reg_addr >> 4) == '0;
  wire logic hit_timing = addr_upper_zero && addr_low == `ACIS_OFF_TIMING;
  wire logic hit_aux = addr_upper_zero && addr_low == `ACIS_OFF_AUX;
  wire logic hit_main = addr_upper_zero && addr_low == `ACIS_OFF_MAIN;
  wire logic hit_scan = addr_upper_zero && addr_low == `ACIS_OFF_SCAN;

  // write masking keeps unimplemented bits at zero
  wire logic [15:0] wr_timing = reg_wdata & `ACIS_MASK_TIMING; // [R15]
  wire logic [15:0] wr_aux = reg_wdata & `ACIS_MASK_AUX; // [R15]
  wire logic [15:0] wr_main = reg_wdata & `ACIS_MASK_MAIN; // [R15]
  wire logic [15:0] wr_scan = reg_wdata & `ACIS_MASK_SCAN; // [R15] [R14]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      adc_timing_control <= `ACIS_RESET_VALUE; // [R16]
    end else if (reg_write && hit_timing) begin
      adc_timing_control <= wr_timing; // [R16]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      adc_aux_channel_select <= `ACIS_RESET_VALUE; // [R16]
    end else if (reg_write && hit_aux) begin
      adc_aux_channel_select <= wr_aux; // [R16]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      adc_main_channel_select <= `ACIS_RESET_VALUE; // [R16]
    end else if (reg_write && hit_main) begin
      adc_main_channel_select <= wr_main; // [R16]
    end
  end

  // every mask bit stays writable, even for inputs a small package lacks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      adc_scan_mask <= `ACIS_RESET_VALUE; // [R16]
    end else if (reg_write && hit_scan) begin
      adc_scan_mask <= wr_scan; // [R16] [R14]
    end
  end

  // unmapped addresses read as zero
  wire logic [15:0] read_value =
    hit_timing ? adc_timing_control :
    hit_aux ? adc_aux_channel_select :
    hit_main ? adc_main_channel_select :
    hit_scan ? adc_scan_mask : 16'h0000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      reg_rdata <= read_value; // [R15]
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // field extraction
  wire logic clock_from_rc = adc_timing_control[`ACIS_TIM_SRC_BIT];
  wire logic [4:0] auto_sample_time = adc_timing_control[`ACIS_TIM_AUTO_SAMPLE_TIME_HI:`ACIS_TIM_AUTO_SAMPLE_TIME_LO];
  wire logic [7:0] conv_clock_divider = adc_timing_control[`ACIS_TIM_DIV_HI:`ACIS_TIM_DIV_LO];
  wire logic [1:0] aux_neg_select_set_b = adc_aux_channel_select[`ACIS_AUX_NEG_B_HI:`ACIS_AUX_NEG_B_LO];
  wire logic aux_pos_select_set_b = adc_aux_channel_select[`ACIS_AUX_POS_B_BIT];
  wire logic [1:0] aux_neg_select_set_a = adc_aux_channel_select[`ACIS_AUX_NEG_A_HI:`ACIS_AUX_NEG_A_LO];
  wire logic aux_pos_select_set_a = adc_aux_channel_select[`ACIS_AUX_POS_A_BIT];
  wire logic main_neg_select_set_b = adc_main_channel_select[`ACIS_MAIN_NEG_B_BIT];
  wire logic [4:0] main_pos_select_set_b = adc_main_channel_select[`ACIS_MAIN_POS_B_HI:`ACIS_MAIN_POS_B_LO];
  wire logic main_neg_select_set_a = adc_main_channel_select[`ACIS_MAIN_NEG_A_BIT];
  wire logic [4:0] main_pos_select_set_a = adc_main_channel_select[`ACIS_MAIN_POS_A_HI:`ACIS_MAIN_POS_A_LO];
  wire logic [12:0] mask = adc_scan_mask[12:0];

  // conversion clock: divider on system clock, or the RC tick
  logic [7:0] div_count;
  wire logic div_wrap = div_count >= conv_clock_divider; // [R4]
  wire logic next_tick = clock_from_rc ? rc_clock_tick : div_wrap; // [R1] [R5]

  always_ff @(posedge clk) begin
    if (sys_rst || clock_from_rc || div_wrap) begin
      div_count <= 8'h00; // [R5]
    end else begin
      div_count <= div_count + 8'h01; // [R4]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_clock_tick <= 1'b0;
    end else begin
      conv_clock_tick <= next_tick; // [R1]
    end
  end

  // reserved divider codes still divide, but are flagged
  assign divider_reserved = !clock_from_rc && conv_clock_divider >= `ACIS_DIV_RESERVED; // [R4] [R5]

  // auto-sample sequencer
  acis_pkg::acis_state_t state;
  acis_pkg::acis_state_t next_state;
  logic [4:0] sample_count;
  wire logic auto_mode = trigger_source == `ACIS_TRIG_AUTO; // [R3] [R20]
  wire logic count_reached = sample_count >= auto_sample_time; // [R2]
  wire logic auto_end_now = state == acis_pkg::ACIS_SAMPLING && auto_mode && count_reached; // [R20]

  always_comb begin
    next_state = state;
    case (state)
      acis_pkg::ACIS_IDLE: begin
        if (sample_start) begin
          next_state = acis_pkg::ACIS_SAMPLING;
        end
      end
      acis_pkg::ACIS_SAMPLING: begin
        if (auto_end_now) begin
          next_state = acis_pkg::ACIS_CONVERTING; // [R20]
        end else if (conversion_done) begin
          next_state = acis_pkg::ACIS_IDLE;
        end
      end
      acis_pkg::ACIS_CONVERTING: begin
        if (conversion_done) begin
          next_state = acis_pkg::ACIS_IDLE;
        end
      end
      default: begin
        next_state = acis_pkg::ACIS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= acis_pkg::ACIS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // sample length counts whole conversion-clock periods
  always_ff @(posedge clk) begin
    if (sys_rst || state != acis_pkg::ACIS_SAMPLING) begin
      sample_count <= 5'h00;
    end else if (conv_clock_tick && !count_reached) begin
      sample_count <= sample_count + 5'h01; // [R2]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      auto_sample_end <= 1'b0;
    end else begin
      auto_sample_end <= auto_end_now; // [R3] [R20]
    end
  end

  assign sampling = state == acis_pkg::ACIS_SAMPLING;

  // sample set alternation
  logic set_b;
  always_ff @(posedge clk) begin
    if (sys_rst || !alternate_sample_flag) begin
      set_b <= 1'b0; // [R18]
    end else if (conversion_done) begin
      set_b <= !set_b; // [R18]
    end
  end

  // next selected scan input above the pointer, wrapping to the lowest
  logic [3:0] scan_ptr;
  logic [3:0] scan_next;
  logic [3:0] scan_first;
  logic scan_found;
  logic [12:0] above_ptr;

  genvar gi;
  generate
    for (gi = 0; gi < 13; gi++) begin : g_above
      assign above_ptr[gi] = mask[gi] && (4'(gi) > scan_ptr); // [R13]
    end
  endgenerate

  always_comb begin
    scan_next = 4'h0;
    scan_first = 4'h0;
    scan_found = 1'b0;
    for (int i = 12; i >= 0; i--) begin
      if (mask[i]) begin
        scan_first = 4'(i); // [R21]
      end
      if (above_ptr[i]) begin
        scan_next = 4'(i); // [R21]
        scan_found = 1'b1;
      end
    end
  end

  wire logic scan_active = scan_enable_set_a && !set_b; // [R17]
  wire logic [3:0] scan_advance = scan_found ? scan_next : scan_first; // [R21]

  // an empty mask leaves the pointer at input 0
  always_ff @(posedge clk) begin
    if (sys_rst || !scan_enable_set_a || mask == 13'h0000) begin
      scan_ptr <= 4'h0;
    end else if (!mask[scan_ptr] && state == acis_pkg::ACIS_IDLE) begin
      scan_ptr <= scan_advance; // [R12]
    end else if (conversion_done && scan_active) begin
      scan_ptr <= scan_advance; // [R21]
    end
  end

  // channel-0 positive selection
  wire logic [4:0] fixed_pos = set_b ? main_pos_select_set_b : main_pos_select_set_a;
  wire logic [4:0] chosen_pos = scan_active ? {1'b0, scan_ptr} : fixed_pos; // [R17] [R10]
  wire logic pos_out_of_range = chosen_pos > `ACIS_POS_MAX; // [R10]
  wire logic pos_absent = SMALL_PACKAGE && chosen_pos >= `ACIS_ABSENT_LO && chosen_pos <= `ACIS_ABSENT_HI;
  wire logic pos_reserved = !scan_active && (pos_out_of_range || pos_absent); // [R11]
  wire logic next_pos_low_ref = pos_out_of_range || pos_absent; // [R14] [R11]

  // channel-0 negative selection
  wire logic next_neg_input1 = set_b ? main_neg_select_set_b : main_neg_select_set_a; // [R9]

  // channel 1-3 selections, meaningful only in four-channel 10-bit operation
  wire logic aux_pos_sel = set_b ? aux_pos_select_set_b : aux_pos_select_set_a;
  wire logic [1:0] aux_neg_sel = set_b ? aux_neg_select_set_b : aux_neg_select_set_a; // [R7]
  wire logic [3:0] next_aux_pos = aux_pos_sel ? `ACIS_AUX_POS_HIGH_BASE : `ACIS_AUX_POS_LOW_BASE; // [R8]
  wire logic neg_high = aux_neg_sel == `ACIS_AUX_NEG_HIGH;
  wire logic neg_mid = aux_neg_sel == `ACIS_AUX_NEG_MID;
  wire logic [3:0] next_aux_neg = neg_high ? `ACIS_AUX_NEG_HIGH_BASE :
    (neg_mid && !SMALL_PACKAGE) ? `ACIS_AUX_NEG_MID_BASE : 4'h0; // [R6]
  wire logic next_aux_low_ref = !neg_high && !(neg_mid && !SMALL_PACKAGE); // [R6]
  wire logic aux_reserved = twelve_bit_mode || (neg_mid && SMALL_PACKAGE); // [R7] [R8] [R19]

  // selections are registered so the multiplexer sees one settled code per cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      using_set_b <= 1'b0;
    end else begin
      using_set_b <= set_b; // [R18]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_pos_input <= 4'h0;
    end else begin
      main_pos_input <= next_pos_low_ref ? 4'h0 : chosen_pos[3:0]; // [R10]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_pos_low_ref <= 1'b0;
    end else begin
      main_pos_low_ref <= next_pos_low_ref; // [R14]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_neg_is_input1 <= 1'b0;
    end else begin
      main_neg_is_input1 <= next_neg_input1; // [R9]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aux_pos_base <= 4'h0;
    end else begin
      aux_pos_base <= next_aux_pos; // [R8]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aux_neg_base <= 4'h0;
    end else begin
      aux_neg_base <= next_aux_neg; // [R6]
    end
  end

  // reset value matches what a cleared select register decodes to
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aux_neg_low_ref <= 1'b1;
    end else begin
      aux_neg_low_ref <= next_aux_low_ref; // [R6]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      select_reserved <= 1'b0;
    end else begin
      select_reserved <= pos_reserved || aux_reserved; // [R11] [R19]
    end
  end

  assign scan_mask_bits = mask; // [R12]
  assign scan_pointer = scan_ptr;

endmodule : acis_top
`default_nettype wire

// *** sim/acis_props.sv ***
// port assertions for the converter clock and input-select block
`timescale 1ns/1ps
`default_nettype none
module acis_props #(parameter int ADDR_WIDTH = 4) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_WIDTH-1:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic [2:0] trigger_source,
  input wire logic alternate_sample_flag,
  input wire logic conversion_done,
  input wire logic auto_sample_end,
  input wire logic sampling,
  input wire logic using_set_b,
  input wire logic [12:0] scan_mask_bits
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire unmapped = reg_addr[0] || (reg_addr > ADDR_WIDTH'(6));
  a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  a_unmapped_zero: assert property (reg_read && unmapped |=> reg_rdata == 16'h0000)
    else $error("unmapped read returned data");
  a_scan_top_zero: assert property (reg_read && reg_addr == ADDR_WIDTH'(6) |=> reg_rdata[15:13] == 3'h0)
    else $error("scan mask upper bits read nonzero");
  a_mask_hold: assert property (!$past(reg_write) |-> $stable(scan_mask_bits))
    else $error("scan mask changed without a write");
  a_end_trigger: assert property (auto_sample_end |-> $past(trigger_source) == 3'h7)
    else $error("auto sample end without auto trigger");
  a_end_sample: assert property (auto_sample_end |-> $past(sampling) && !sampling)
    else $error("auto sample end outside sampling");
  a_end_pulse: assert property (auto_sample_end |=> !auto_sample_end)
    else $error("auto sample end longer than one cycle");
  a_set_a_fixed: assert property (!alternate_sample_flag [*3] |-> !using_set_b)
    else $error("set b used with alternate flag clear");
  a_alt_toggle: assert property (conversion_done && alternate_sample_flag ##1 alternate_sample_flag
    |-> ##1 using_set_b != $past(using_set_b))
    else $error("sample set did not alternate");
  c_auto_end: cover property (auto_sample_end);
  c_alternate: cover property (conversion_done && alternate_sample_flag);
  c_unmapped: cover property (reg_read && unmapped);
endmodule : acis_props
bind acis_top acis_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (.clk, .sys_rst, .reg_addr, .reg_write, .reg_read,
  .reg_rdata, .trigger_source, .alternate_sample_flag, .conversion_done, .auto_sample_end, .sampling,
  .using_set_b, .scan_mask_bits);
`default_nettype wire

// *** sim/acis_tb.sv ***
// self-checking bench for the converter clock and input-select block
`timescale 1ns/1ps
`default_nettype none
`include "acis_defs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
  logic clk = 0, sys_rst = 1, reg_write = 0, reg_read = 0, twelve_bit_mode = 0, scan_enable_set_a = 0;
  logic alternate_sample_flag = 0, rc_clock_tick = 0, sample_start = 0, conversion_done = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [2:0] trigger_source = 3'h0;
  wire [15:0] reg_rdata;
  wire conv_clock_tick, auto_sample_end, sampling, using_set_b, main_pos_low_ref, main_neg_is_input1;
  wire aux_neg_low_ref, select_reserved, divider_reserved;
  wire [3:0] main_pos_input, aux_pos_base, aux_neg_base, scan_pointer;
  wire [12:0] scan_mask_bits;
  int failures = 0, n_checks = 0, ticks = 0;
  acis_top DUT (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .twelve_bit_mode,
    .trigger_source, .scan_enable_set_a, .alternate_sample_flag, .rc_clock_tick, .sample_start,
    .conversion_done, .conv_clock_tick, .auto_sample_end, .sampling, .using_set_b, .main_pos_input,
    .main_pos_low_ref, .main_neg_is_input1, .aux_pos_base, .aux_neg_base, .aux_neg_low_ref, .select_reserved,
    .divider_reserved, .scan_mask_bits, .scan_pointer);
  // smallest package variant shares every input; only its reserved and low-reference outputs are watched
  wire sm_low_ref, sm_reserved, sm_aux_low;
  acis_top #(.SMALL_PACKAGE(1'b1)) dut_small (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata(), .twelve_bit_mode, .trigger_source, .scan_enable_set_a, .alternate_sample_flag, .rc_clock_tick,
    .sample_start, .conversion_done, .conv_clock_tick(), .auto_sample_end(), .sampling(), .using_set_b(),
    .main_pos_input(), .main_pos_low_ref(sm_low_ref), .main_neg_is_input1(), .aux_pos_base(), .aux_neg_base(),
    .aux_neg_low_ref(sm_aux_low), .select_reserved(sm_reserved), .divider_reserved(), .scan_mask_bits(),
    .scan_pointer());
  always #4 clk = ~clk;
  // count on the falling edge so clearing from the main flow never races the count
  always @(negedge clk) if (conv_clock_tick === 1'b1) ticks++;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : rd
  task automatic pulse(int w);
    @(posedge clk);
    if (w == 0) sample_start <= 1'b1;
    else if (w == 1) conversion_done <= 1'b1;
    else rc_clock_tick <= 1'b1;
    @(posedge clk);
    {sample_start, conversion_done, rc_clock_tick} <= 3'b000;
  endtask : pulse
  function automatic logic [4:0] aneg(logic [1:0] c);
    return c == 2'h3 ? 5'h09 : c == 2'h2 ? 5'h06 : 5'h10;
  endfunction : aneg
  function automatic logic [4:0] mpos(logic [4:0] c);
    return c > 5'h0C ? 5'h10 : {1'b0, c[3:0]};
  endfunction : mpos
  function automatic logic [3:0] nxt(logic [12:0] k, logic [3:0] p);
    for (int i = 1; i <= 13; i++) if (k[(p + i) % 13]) return 4'((p + i) % 13);
    return p;
  endfunction : nxt
  task automatic chk_sel(logic [15:0] m, logic [15:0] x, logic b);
    logic [7:0] mm;
    logic [7:0] xx;
    logic ab;
    mm = b ? m[15:8] : m[7:0];
    xx = b ? x[15:8] : x[7:0];
    ab = mm[4:0] > 5'h0C || (mm[4:0] >= 5'h06 && mm[4:0] <= 5'h08);
    `CHK(sm_low_ref, ab)
    `CHK(sm_reserved, ab || xx[2:1] == 2'h2)
    `CHK(sm_aux_low, xx[2:1] != 2'h3)
    `CHK(using_set_b, b)
    `CHK({main_pos_low_ref, main_pos_input}, mpos(mm[4:0]))
    `CHK(main_neg_is_input1, mm[7])
    `CHK(aux_pos_base, xx[0] ? 4'h3 : 4'h0)
    `CHK({aux_neg_low_ref, aux_neg_base}, aneg(xx[2:1]))
    `CHK(select_reserved, mm[4:0] > 5'h0C)
  endtask : chk_sel
  initial begin #400000; failures++; wrap_up(); end
  initial begin
    logic [15:0] msk [4];
    logic [15:0] m, x, d;
    logic [7:0] dv [3];
    logic [4:0] s [3];
    logic b;
    int n;
    logic [3:0] p;
    msk = '{`ACIS_MASK_TIMING, `ACIS_MASK_AUX, `ACIS_MASK_MAIN, `ACIS_MASK_SCAN};
    n = $urandom(32'h4526ab57);
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(1);
    `CHK(aux_neg_low_ref, 1'b1)
    for (int i = 0; i < 4; i++) rd(4'(2 * i), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      wr(4'(2 * i), d);
      rd(4'(2 * i), d & msk[i]);
    end
    wr(4'h8, 16'hFFFF);
    rd(4'h8, 16'h0000);
    rd(4'h6, d & 16'h1FFF);
    `CHK(scan_mask_bits, d[12:0])
    $display("test registers done");
    dv = '{8'h00, 8'(1 + $urandom % 6), 8'h3F};
    foreach (dv[k]) begin
      wr(`ACIS_OFF_TIMING, {8'h00, dv[k]});
      cyc(260);
      ticks = 0;
      cyc(8 * (dv[k] + 1));
      `CHK(ticks, 8)
      `CHK(divider_reserved, 1'b0)
    end
    wr(`ACIS_OFF_TIMING, 16'h0040);
    cyc(1);
    `CHK(divider_reserved, 1'b1)
    wr(`ACIS_OFF_TIMING, 16'h80FF);
    cyc(2);
    `CHK(divider_reserved, 1'b0)
    ticks = 0;
    repeat (5) begin
      pulse(2);
      cyc(3);
    end
    `CHK(ticks, 5)
    $display("test clock done");
    s = '{5'h00, 5'(1 + $urandom % 29), 5'h1F};
    @(posedge clk);
    trigger_source <= 3'h7;
    foreach (s[k]) begin
      wr(`ACIS_OFF_TIMING, {3'h0, s[k], 8'h00});
      pulse(0);
      n = 0;
      while (auto_sample_end !== 1'b1 && n < 100) begin
        cyc(1);
        n++;
      end
      `CHK((n >= s[k] + 1 && n <= s[k] + 3), 1'b1)
      if (n == 100) wrap_up();
      pulse(1);
      cyc(1);
      `CHK(sampling, 1'b0)
    end
    @(posedge clk);
    trigger_source <= 3'h0;
    pulse(0);
    cyc(40);
    `CHK(sampling, 1'b1)
    pulse(1);
    $display("test sampling done");
    alternate_sample_flag <= 1'b1;
    b = 1'b0;
    for (int i = 0; i < 6; i++) begin
      m = i == 0 ? 16'h8D0C : i == 1 ? 16'h0787 : $urandom & `ACIS_MASK_MAIN;
      x = i == 0 ? 16'h0406 : $urandom & `ACIS_MASK_AUX;
      wr(`ACIS_OFF_MAIN, m);
      wr(`ACIS_OFF_AUX, x);
      cyc(3);
      chk_sel(m, x, b);
      pulse(1);
      cyc(3);
      b = ~b;
      chk_sel(m, x, b);
    end
    pulse(1);
    twelve_bit_mode <= 1'b1;
    cyc(3);
    `CHK(select_reserved, 1'b1)
    `CHK(using_set_b, 1'b1)
    @(posedge clk);
    twelve_bit_mode <= 1'b0;
    alternate_sample_flag <= 1'b0;
    cyc(4);
    `CHK(using_set_b, 1'b0)
    $display("test selection done");
    d = ($urandom & 16'h1FFF) | 16'h1081;
    wr(`ACIS_OFF_SCAN, d);
    wr(`ACIS_OFF_MAIN, 16'h0005);
    scan_enable_set_a <= 1'b1;
    cyc(4);
    p = scan_pointer;
    `CHK(d[p], 1'b1)
    repeat (8) begin
      `CHK(main_pos_input, p)
      `CHK(sm_low_ref, p >= 4'h6 && p <= 4'h8)
      pulse(1);
      cyc(3);
      p = nxt(d[12:0], p);
      `CHK(scan_pointer, p)
    end
    @(posedge clk);
    scan_enable_set_a <= 1'b0;
    cyc(3);
    `CHK(main_pos_input, 4'h5)
    $display("test scan done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
